// *** pkg/dtd_regs.vh ***
`ifndef DTD_REGS_VH
`define DTD_REGS_VH
// Frame layout: 8 command bits, 16 data bits, 2 spare, 6 check/spare bits
`define DTD_FRAME_BITS 32
`define DTD_CNT_W 6
`define DTD_CMD_HI 31
`define DTD_CMD_LO 24
`define DTD_DAT_HI 23
`define DTD_DAT_LO 8
// Command byte codes
`define DTD_CMD_BANK_SEL 8'h72
`define DTD_CMD_SW_TOGGLE 8'h73
`define DTD_CMD_WAVE_EN 8'h74
`define DTD_CMD_CH_SET 4'h1
`define DTD_CMD_CODE_WR 4'h0
// Channel settings field positions inside the 16 data bits
`define DTD_SET_MODE 8
`define DTD_SET_SRC_HI 5
`define DTD_SET_SRC_LO 4
`define DTD_SET_PER_HI 2
`define DTD_SET_PER_LO 0
`define DTD_SET_PH_HI 7
`define DTD_SET_PH_LO 6
// Clock source codes
`define DTD_SRC_SW 2'h0
`define DTD_SRC_P0 2'h1
`define DTD_SRC_P1 2'h2
`define DTD_SRC_P2 2'h3
// Reset values and channel count
`define DTD_RST8 8'h00
`define DTD_RST16 16'h0000
`define DTD_NCH 8
`endif

// *** logic/dtd_sine_lut.v ***
`timescale 1ns/1ps
// Quarter-sine table in 1/32 steps (64-sample column), registered read
module dtd_sine_lut (
    input wire clk_i, // System clock
    input wire [3:0] q_i, // Quarter index 0..15 (16 handled by caller)
    output reg [4:0] val_o // Sample magnitude in 1/32 units
);
    // Registered lookup; values are the N=64 column times 32
    always @(posedge clk_i) begin
        case (q_i)
            4'h0: val_o <= 5'h00;
            4'h1: val_o <= 5'h03;
            4'h2: val_o <= 5'h06;
            4'h3: val_o <= 5'h09;
            4'h4: val_o <= 5'h0c;
            4'h5: val_o <= 5'h0f;
            4'h6: val_o <= 5'h12;
            4'h7: val_o <= 5'h15;
            4'h8: val_o <= 5'h18;
            4'h9: val_o <= 5'h19;
            4'ha: val_o <= 5'h1b;
            4'hb: val_o <= 5'h1c;
            4'hc: val_o <= 5'h1e;
            4'hd: val_o <= 5'h1f;
            4'he: val_o <= 5'h1f;
            default: val_o <= 5'h1f; // 15; full scale 32 handled outside
        endcase
    end
endmodule // dtd_sine_lut

// *** logic/dtd_ctrl.v ***
`timescale 1ns/1ps
`include "dtd_regs.vh"
// Overview of operation
// RULE1: Command 0x72 writes input bank select.
// RULE2: Bank bit picks register A or B.
// RULE3: Command 0x73 writes software toggle bits.
// RULE4: Toggle bits change only at frame latch.
// RULE5: Command 0x74 writes enable bits.
// RULE6: Toggle channel disabled returns to A.
// RULE7: Dither disabled finishes period, then A.
// RULE8: Host gives N clocks before new codes.
// RULE9: Enabled dither steps on clock rising edge.
// RULE10: Not yet enabled channel outputs A.
// RULE11: Code write 0000 addr uses bank bit.
// RULE12: Host zeroes two amplitude LSBs.
// RULE13: Full dither amplitude is quarter span.
// RULE14: Mode 1 dither, source 10, period 64.
// RULE15: Host clocks at N times sine frequency.
// RULE16: Source code picks software bit or pin.
// RULE17: Period code selects N from 4 to 64.
// RULE18: Phase code picks 0/90/180/270 start.
// RULE19: Dither output is A plus B times D.
// RULE20: Frame is 32 bits, latched at rise.
// RULE21: Enable starts index at phase position.
module dtd_ctrl (
    input wire CLK_I, // System clock 100 MHz
    input wire RST_N_I, // Async reset, active low
    input wire SCK_I, // Serial clock pin
    input wire SDI_I, // Serial data pin
    input wire FRAME_LATCH_SELECT_N_I, // Frame select, low during frame
    input wire [2:0] WAVE_PINS_I, // External wave pins first..third
    input wire [2:0] CH_SEL_I, // Channel whose output code is shown
    output reg [15:0] DAC_CODE_O, // Output code of selected channel
    output reg [7:0] WAVE_ACTIVE_O // Channels currently in toggle/dither
);
    integer k; // Loop index for the register file
    integer j; // Loop index for clock selection, kept apart so each process owns its own
    integer m; // Loop index for the wave engine
    // Two-stage synchronisers for pins
    reg [5:0] s1_reg;
    reg [5:0] s2_reg;
    reg [5:0] s3_reg; // Previous synced value for edge detection
    wire sck_rise = s2_reg[0] & ~s3_reg[0];
    wire cs_fall = ~s2_reg[2] & s3_reg[2];
    wire cs_rise = s2_reg[2] & ~s3_reg[2];
    always @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            s1_reg <= 6'h3f;
            s2_reg <= 6'h3f;
            s3_reg <= 6'h3f;
        end else begin
            s1_reg <= {WAVE_PINS_I, FRAME_LATCH_SELECT_N_I, SDI_I, SCK_I};
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end
    // Frame shifter; the last 32 bits before the latch edge count
    reg [31:0] sh_reg;
    reg [`DTD_CNT_W:0] cnt_reg;
    always @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            sh_reg <= 32'h00000000;
            cnt_reg <= 7'h00;
        end else if (cs_fall) begin
            cnt_reg <= 7'h00;
        end else if (sck_rise && !s2_reg[2]) begin
            sh_reg <= {sh_reg[30:0], s2_reg[1]};
            if (cnt_reg != 7'h7f) begin
                cnt_reg <= cnt_reg + 7'h01;
            end
        end
    end
    wire frame_ok = cs_rise && (cnt_reg >= `DTD_FRAME_BITS); // RULE20
    wire [7:0] cmd = sh_reg[`DTD_CMD_HI:`DTD_CMD_LO];
    wire [15:0] dat = sh_reg[`DTD_DAT_HI:`DTD_DAT_LO];
    wire [7:0] odd_bits = {dat[14], dat[12], dat[10], dat[8], dat[6], dat[4], dat[2], dat[0]};
    wire [2:0] adr = cmd[2:0];
    // Registers and per-channel storage
    reg [7:0] input_bank_select_reg;
    reg [7:0] software_toggle_bits_reg;
    reg [7:0] wave_activate_bits_reg;
    reg [15:0] a_reg [0:7];
    reg [15:0] b_reg [0:7];
    reg [7:0] mode_reg;
    reg [1:0] wave_clock_source_reg [0:7];
    reg [2:0] wave_period_code_reg [0:7];
    reg [1:0] wave_phase_code_reg [0:7];
    always @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            input_bank_select_reg <= `DTD_RST8;
            software_toggle_bits_reg <= `DTD_RST8;
            wave_activate_bits_reg <= `DTD_RST8;
            mode_reg <= `DTD_RST8;
            for (k = 0; k < `DTD_NCH; k = k + 1) begin
                a_reg[k] <= `DTD_RST16;
                b_reg[k] <= `DTD_RST16;
                wave_clock_source_reg[k] <= `DTD_SRC_SW; // RULE16
                wave_period_code_reg[k] <= 3'h0; // RULE17
                wave_phase_code_reg[k] <= 2'h0; // RULE18
            end
        end else if (frame_ok) begin
            if (cmd == `DTD_CMD_BANK_SEL) begin
                input_bank_select_reg <= odd_bits; // RULE1
            end else if (cmd == `DTD_CMD_SW_TOGGLE) begin
                software_toggle_bits_reg <= odd_bits; // RULE3 RULE4
            end else if (cmd == `DTD_CMD_WAVE_EN) begin
                wave_activate_bits_reg <= odd_bits; // RULE5
            end else if (cmd[7:4] == `DTD_CMD_CODE_WR && !cmd[3]) begin
                // Bank bit steers the code into A or B
                if (input_bank_select_reg[adr]) begin // RULE2 RULE11
                    b_reg[adr] <= dat;
                end else begin
                    a_reg[adr] <= dat;
                end
            end else if (cmd[7:4] == `DTD_CMD_CH_SET && !cmd[3]) begin
                mode_reg[adr] <= dat[`DTD_SET_MODE]; // RULE14
                wave_clock_source_reg[adr] <= dat[`DTD_SET_SRC_HI:`DTD_SET_SRC_LO];
                wave_period_code_reg[adr] <= dat[`DTD_SET_PER_HI:`DTD_SET_PER_LO];
                wave_phase_code_reg[adr] <= dat[`DTD_SET_PH_HI:`DTD_SET_PH_LO];
            end
        end
    end
    // Per-channel wave engine: index counts 0..63 in 64-sample units
    reg [7:0] run_reg; // Channel still producing waves
    reg [7:0] tck_prev_reg;
    reg [5:0] idx_reg [0:7];
    reg [5:0] start_reg [0:7]; // Index where the period began
    reg [5:0] step [0:7]; // Index step per channel in 64ths
    reg [7:0] tck;
    // Clock source mux and step size; combinational so the engine stays purely registered
    always @* begin
        for (j = 0; j < `DTD_NCH; j = j + 1) begin
            // Step size in 64ths: 16 for N=4 down to 1 for N=64
            step[j] = 6'h10 >> wave_period_code_reg[j]; // RULE17
            case (wave_clock_source_reg[j]) // RULE16 RULE14
                `DTD_SRC_SW: tck[j] = software_toggle_bits_reg[j];
                `DTD_SRC_P0: tck[j] = s2_reg[3];
                `DTD_SRC_P1: tck[j] = s2_reg[4];
                default: tck[j] = s2_reg[5];
            endcase
        end
    end
    always @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            run_reg <= `DTD_RST8;
            tck_prev_reg <= `DTD_RST8;
            for (m = 0; m < `DTD_NCH; m = m + 1) begin
                idx_reg[m] <= 6'h00;
                start_reg[m] <= 6'h00;
            end
        end else begin
            tck_prev_reg <= tck;
            for (m = 0; m < `DTD_NCH; m = m + 1) begin
                if (wave_activate_bits_reg[m] && !run_reg[m]) begin
                    run_reg[m] <= 1'b1;
                    idx_reg[m] <= {wave_phase_code_reg[m], 4'h0}; // RULE21 RULE18
                    start_reg[m] <= {wave_phase_code_reg[m], 4'h0};
                end else if (run_reg[m] && !mode_reg[m] && !wave_activate_bits_reg[m]) begin
                    run_reg[m] <= 1'b0; // RULE6
                end else if (run_reg[m] && mode_reg[m] && tck[m] && !tck_prev_reg[m]) begin
                    idx_reg[m] <= idx_reg[m] + step[m]; // RULE9
                    // Stop once the period wraps back to its start when disabled
                    if (!wave_activate_bits_reg[m] && (idx_reg[m] + step[m] == start_reg[m])) begin
                        run_reg[m] <= 1'b0; // RULE7
                    end
                end
            end
        end
    end
    // Output path for the selected channel
    wire [5:0] ix = idx_reg[CH_SEL_I];
    // Mirror the second and fourth quarters; 4-bit wrap gives 16 - i, and 16 itself is caught by full
    wire [3:0] q = ix[4] ? (4'h0 - ix[3:0]) : ix[3:0];
    // Peak samples equal one: table entries 15 and 16 both reach full scale
    wire full = (ix[4] && ix[3:0] == 4'h0) || (q == 4'hf);
    wire [4:0] mag;
    dtd_sine_lut u_lut (
        .clk_i(CLK_I),
        .q_i(q),
        .val_o(mag)
    );
    reg [2:0] ch_d_reg;
    reg full_d_reg;
    reg neg_d_reg;
    always @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            ch_d_reg <= 3'h0;
            full_d_reg <= 1'b0;
            neg_d_reg <= 1'b0;
        end else begin
            ch_d_reg <= CH_SEL_I;
            full_d_reg <= full;
            neg_d_reg <= ix[5];
        end
    end
    // B times D, where D is mag/32 and full amplitude is a quarter span
    wire [15:0] bv = b_reg[ch_d_reg];
    wire [21:0] prod = full_d_reg ? {1'b0, bv, 5'h00} : bv * {1'b0, mag}; // RULE13
    wire [15:0] delta = prod[20:5] >> 2; // RULE13
    wire [15:0] av = a_reg[ch_d_reg];
    wire [15:0] wave = neg_d_reg ? av - delta : av + delta; // RULE19
    wire sel_tck = tck[ch_d_reg];
    always @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            DAC_CODE_O <= `DTD_RST16;
            WAVE_ACTIVE_O <= `DTD_RST8;
        end else begin
            WAVE_ACTIVE_O <= run_reg;
            if (!run_reg[ch_d_reg]) begin
                DAC_CODE_O <= av; // RULE10 RULE6
            end else if (mode_reg[ch_d_reg]) begin
                DAC_CODE_O <= wave; // RULE9
            end else begin
                DAC_CODE_O <= sel_tck ? av : b_reg[ch_d_reg];
            end
        end
    end
endmodule // dtd_ctrl

// *** tb/dtd_checker.sv ***
`timescale 1ns/1ps
// Output changes must follow pin activity that can cause them
module dtd_checker (
    input wire CLK_I, // Clock
    input wire RST_N_I, // Reset, active low
    input wire FRAME_LATCH_SELECT_N_I, // Select
    input wire [2:0] WAVE_PINS_I, // Wave pins
    input wire [2:0] CH_SEL_I, // View
    input wire [15:0] DAC_CODE_O, // Code
    input wire [7:0] WAVE_ACTIVE_O // Active
);
    reg [3:0] pc; // Age of last pin or view change
    reg [3:0] fc; // Age of last select or view change
    wire fresh = (pc < 4'hc) || (fc < 4'hc); // Sync plus table latency fits in 12
    // Saturating ages, so long idle spans never wrap
    always @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            pc <= 4'h0;
            fc <= 4'h0;
        end else begin
            pc <= ($changed(WAVE_PINS_I) || $changed(CH_SEL_I)) ? 4'h0
                : pc + {3'h0, pc != 4'hf};
            fc <= ($changed(FRAME_LATCH_SELECT_N_I) || $changed(CH_SEL_I)) ? 4'h0
                : fc + {3'h0, fc != 4'hf};
        end
    end
    default clocking @(posedge CLK_I); endclocking
    default disable iff (!RST_N_I);
    sequence shifting; (!FRAME_LATCH_SELECT_N_I) [*8]; endsequence
    sequence idle; (WAVE_ACTIVE_O == 8'h00) [*8]; endsequence
    a_reset_clears: assert property ($rose(RST_N_I) |-> !DAC_CODE_O && !WAVE_ACTIVE_O)
        else $error("outputs set after reset");
    a_dac_cause: assert property ($changed(DAC_CODE_O) |-> fresh)
        else $error("code moved without cause");
    a_active_cause: assert property ($changed(WAVE_ACTIVE_O) |-> fresh)
        else $error("active moved without cause");
    a_no_rise_shift: assert property (shifting |-> !(WAVE_ACTIVE_O & ~$past(WAVE_ACTIVE_O)))
        else $error("enable during shifting");
    a_rise_latch: assert property ((WAVE_ACTIVE_O & ~$past(WAVE_ACTIVE_O)) != 8'h00
        |-> FRAME_LATCH_SELECT_N_I && fc < 4'hc) else $error("enable without latch");
    a_idle_holds: assert property (idle ##0 fc == 4'hf |-> $stable(DAC_CODE_O))
        else $error("idle code moved");
    a_idle_latch: assert property (idle ##0 $changed(DAC_CODE_O)
        |-> FRAME_LATCH_SELECT_N_I && fc < 4'hc) else $error("write without latch");
    a_shift_hold: assert property (shifting ##0 pc == 4'hf |-> $stable(DAC_CODE_O))
        else $error("code moved while shifting");
endmodule // dtd_checker
bind dtd_ctrl dtd_checker dtd_checker_i (.CLK_I(CLK_I), .RST_N_I(RST_N_I),
    .FRAME_LATCH_SELECT_N_I(FRAME_LATCH_SELECT_N_I), .WAVE_PINS_I(WAVE_PINS_I),
    .CH_SEL_I(CH_SEL_I), .DAC_CODE_O(DAC_CODE_O), .WAVE_ACTIVE_O(WAVE_ACTIVE_O));

// *** tb/dtd_host.sv ***
`timescale 1ns/1ps
// Host: frames on the serial pins, edges on the wave pins
module dtd_host (
    output reg sck_o, // Serial clock, still between frames
    output reg sdi_o, // Serial data
    output reg sel_n_o, // Frame select, active low
    output reg [2:0] pins_o // Wave pins
);
    initial {sck_o, sdi_o, sel_n_o, pins_o} = 6'h08;
    // One frame, MSB first, data moved while the clock is low
    task frame(input [7:0] c, input [15:0] d);
        integer i;
        reg [31:0] w;
        begin
            w = {c, d, 8'h00};
            sel_n_o = 1'b0;
            for (i = 31; i >= 0; i = i - 1) begin
                #40 sck_o = 1'b0;
                sdi_o = w[i];
                #40 sck_o = 1'b1;
            end
            #40 sck_o = 1'b0;
            sdi_o = ~sdi_o; // Stale data never lingers
            #40 sel_n_o = 1'b1;
            #300;
        end
    endtask
    // Rising edges; after a stop the host owes N of them
    task pulse(input integer p, input integer n);
        integer k;
        for (k = 0; k < n; k = k + 1) begin
            pins_o[p] = 1'b1;
            #160 pins_o[p] = 1'b0;
            #160;
        end
    endtask
    task hold(input integer p, input v);
        begin
            pins_o[p] = v;
            #200;
        end
    endtask
endmodule // dtd_host

// *** tb/dtd_ctrl_tb.sv ***
`timescale 1ns/1ps
// Code table, toggle, dither and reset
module dtd_ctrl_tb;
    reg clk = 1'b0; // Clock
    reg rst_n = 1'b0; // Reset, active low
    reg [2:0] ch_sel = 3'h0; // View
    wire sck, sdi, sel_n; // Serial pins
    wire [2:0] pins; // Wave pins
    wire [15:0] dac; // Code
    wire [7:0] act; // Active
    integer bad_count = 0; // Mismatches
    integer check_count = 0; // Compares
    integer r; // Row
    // Bank, channel, code, expected view
    reg [35:0] rows [0:3] = '{36'h0b333b333, 36'h80400b333, 36'h712341234, 36'hf00401234};
    // Period, phase, code after one step (A 8000, B 0400)
    reg [20:0] dith [0:7] = '{21'h08100, 21'h480c0, 21'h88060, 21'hc8030,
        21'h108018, 21'h118100, 21'h127fe8, 21'h137f00};
    dtd_ctrl dtd_ctrl_i (.CLK_I(clk), .RST_N_I(rst_n), .SCK_I(sck), .SDI_I(sdi),
        .FRAME_LATCH_SELECT_N_I(sel_n), .WAVE_PINS_I(pins), .CH_SEL_I(ch_sel),
        .DAC_CODE_O(dac), .WAVE_ACTIVE_O(act));
    dtd_host dtd_host_i (.sck_o(sck), .sdi_o(sdi), .sel_n_o(sel_n), .pins_o(pins));
    initial begin
        forever #5 clk = ~clk;
    end
    task check(input [15:0] seen, input [15:0] exp);
        begin
            check_count = check_count + 1;
            if (seen !== exp) begin
                bad_count = bad_count + 1;
                $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
            end
        end
    endtask
    task conclude;
        begin
            $display("compares %0d mismatches %0d", check_count, bad_count);
            if (bad_count == 0 && check_count > 0)
                $display("STATUS OK");
            else
                $display("STATUS NOT OK");
            $finish;
        end
    endtask
    // Channel x sits in data bit 2x
    function [15:0] spread(input [7:0] b);
        integer i;
        begin
            spread = 16'h0000;
            for (i = 0; i < 8; i = i + 1) spread[2 * i] = b[i];
        end
    endfunction
    task wr(input [7:0] c, input [15:0] d); dtd_host_i.frame(c, d); endtask
    task view(input [2:0] c);
        begin
            @(posedge clk) ch_sel <= c;
            repeat (4) @(posedge clk);
        end
    endtask
    initial begin
        #900000 bad_count = bad_count + 1;
        conclude;
    end
    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        for (r = 0; r < 4; r = r + 1) begin
            wr(8'h72, spread({7'h00, rows[r][35]} << rows[r][34:32]));
            wr({5'h00, rows[r][34:32]}, rows[r][31:16]);
            view(rows[r][34:32]);
            check(dac, rows[r][15:0]);
        end
        $display("rows done");
        view(3'h0);
        wr(8'h10, 16'h0000);
        wr(8'h74, spread(8'h01));
        check({8'h00, act}, 16'h0001);
        check(dac, 16'h0400);
        wr(8'h73, spread(8'h01));
        check(dac, 16'hb333);
        for (r = 1; r < 4; r = r + 1) begin
            wr(8'h10, {10'h000, r[1:0], 4'h0});
            dtd_host_i.hold(r - 1, 1'b1);
            check(dac, 16'hb333);
            dtd_host_i.hold(r - 1, 1'b0);
            check(dac, 16'h0400);
        end
        wr(8'h74, 16'h0000);
        check(dac, 16'hb333);
        $display("toggle done");
        wr(8'h72, 16'h0000);
        wr(8'h01, 16'h8000);
        wr(8'h72, spread(8'h02));
        wr(8'h01, 16'h0400);
        view(3'h1);
        for (r = 0; r < 8; r = r + 1) begin
            wr(8'h11, {7'h00, 1'b1, dith[r][17:16], 2'h2, 1'b0, dith[r][20:18]});
            wr(8'h74, spread(8'h02));
            dtd_host_i.pulse(1, 1);
            check(dac, dith[r][15:0]);
            wr(8'h74, 16'h0000);
            dtd_host_i.pulse(1, (4 << dith[r][20:18]) - 2);
            check({8'h00, act}, 16'h0002);
            dtd_host_i.pulse(1, 1);
            check({8'h00, act}, 16'h0000);
            check(dac, 16'h8000);
        end
        $display("dither done");
        @(posedge clk) rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        check(dac | {8'h00, act}, 16'h0000);
        @(posedge clk) rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        view(3'h0);
        wr(8'h00, 16'h5550);
        wr(8'h08, 16'h1111);
        check(dac, 16'h5550);
        wr(8'h72, spread(8'h01));
        wr(8'h00, 16'h00a0);
        check(dac, 16'h5550);
        wr(8'h74, spread(8'h01));
        check(dac, 16'h00a0);
        $display("reset done");
        conclude;
    end
endmodule // dtd_ctrl_tb
